/* core/nvwc_pkg.sv */
// Constants, types and encodings for the interrupt and wake controller.
// Assumes one 100 MHz system clock and a synchronous active-high reset.
package nvwc_pkg;
  localparam int unsigned NVWC_NUM_EXC    = 38;
  localparam int unsigned NVWC_NUM_CORE   = 15;
  localparam int unsigned NVWC_NUM_IRQ    = 23;
  localparam int unsigned NVWC_NUM_LINES  = 24;
  localparam int unsigned NVWC_PRIO_W     = 2;
  localparam int unsigned NVWC_EXC_W      = 6;
  localparam int unsigned NVWC_IRQ_IDX_W  = 5;
  // Exception numbers
  localparam logic [5:0] NVWC_EXC_NONE    = 6'h00;
  localparam logic [5:0] NVWC_EXC_RESET   = 6'h01;
  localparam logic [5:0] NVWC_EXC_NMI     = 6'h02;
  localparam logic [5:0] NVWC_EXC_HARD    = 6'h03;
  localparam logic [5:0] NVWC_EXC_SVCALL  = 6'h0B;
  localparam logic [5:0] NVWC_EXC_PENDSRV = 6'h0E;
  localparam logic [5:0] NVWC_EXC_TICK    = 6'h0F;
  localparam logic [5:0] NVWC_EXC_IRQ0    = 6'h10;
  // Line 17 (exception 33) is reserved
  localparam int unsigned NVWC_RSVD_LINE  = 17;
  // Wake and reserved-line masks over the 24 peripheral lines (bit n = exception 16+n)
  localparam logic [23:0] NVWC_SLEEP_WAKE = 24'hFD_FE7F;
  localparam logic [23:0] NVWC_HIB_WAKE   = 24'h00_000B;
  localparam logic [23:0] NVWC_RSVD_MASK  = 24'hFD_FFFF;
  // Core-exception priority slots
  localparam int unsigned NVWC_SLOT_SVC   = 0;
  localparam int unsigned NVWC_SLOT_PSV   = 1;
  localparam int unsigned NVWC_SLOT_TICK  = 2;
  localparam int unsigned NVWC_NUM_SLOTS  = 3;
  // Internal rank: 0 fixed reset .. 2 hard fault, 3..6 programmable 0..3
  localparam logic [2:0] NVWC_RANK_RESET  = 3'h0;
  localparam logic [2:0] NVWC_RANK_NMI    = 3'h1;
  localparam logic [2:0] NVWC_RANK_HARD   = 3'h2;
  localparam logic [2:0] NVWC_RANK_PROG   = 3'h3;
  localparam logic [2:0] NVWC_RANK_IDLE   = 3'h7;

  typedef enum logic [1:0] {
    NVWC_NMI_OFF  = 2'b00,
    NVWC_NMI_PIN  = 2'b01,
    NVWC_NMI_CLK  = 2'b10,
    NVWC_NMI_BROWN = 2'b11
  } nvwc_nmi_sel_t;

  typedef enum logic [1:0] {
    NVWC_PM_RUN   = 2'b00,
    NVWC_PM_SLEEP = 2'b01,
    NVWC_PM_HIB   = 2'b10,
    NVWC_PM_SHUT  = 2'b11
  } nvwc_pmode_t;
endpackage

/* core/nvwc_prio_mem.sv */
// Priority store for the peripheral lines and programmable exceptions.
// Assumes one writer; all read values are registered each cycle.
`timescale 1ns/1ns
module nvwc_prio_mem
  import nvwc_pkg::*;
(
  // Clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        srst_in,
  // Write port
  input  wire logic                        wr_en_in,
  input  wire logic [4:0]                  wr_idx_in,
  input  wire logic [NVWC_PRIO_W-1:0]      wr_data_in,
  // Registered read of every entry
  output logic [NVWC_NUM_LINES+NVWC_NUM_SLOTS-1:0][NVWC_PRIO_W-1:0] rd_out
);
  localparam int unsigned DEPTH = NVWC_NUM_LINES + NVWC_NUM_SLOTS;
  logic [DEPTH-1:0][NVWC_PRIO_W-1:0] next_rd;

  // Next contents: one entry written per cycle
  always_comb begin
    next_rd = rd_out;
    if (wr_en_in && (32'(wr_idx_in) < DEPTH)) begin
      next_rd[wr_idx_in] = wr_data_in;
    end
  end

  // All entries reset to the highest programmable level
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rd_out <= '0;
    end else begin
      rd_out <= next_rd;
    end
  end
endmodule

/* core/nvwc_ctrl.sv */
// Nested prioritised interrupt controller with wake-up control.
// Assumes the core acknowledges entry and return with one-cycle pulses
// and that peripheral requests are synchronous to sys_clk_in.
// Summary of operation
// - 38 exceptions: 15 core, 23 peripheral
// - Four software-set priority levels per line and for SVC, PendSV, tick
// - Preempt only on strictly higher priority
// - Equal priority: lower polling number first
// - Selectable NMI from pin, clock loss, brownout
// - Reset, NMI, hard fault fixed above all
// - Peripherals at 16-39, 33 reserved
// - Sleep wake: all but flash, watchdog
// - Hibernate: NMI, 16, 17, 19; shutdown: pin
// - Brownout warning may drive the NMI
// - Clock loss forces switch to internal oscillator
`timescale 1ns/1ns
module nvwc_ctrl
  import nvwc_pkg::*;
(
  // Clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        srst_in,
  // Peripheral and core requests
  input  wire logic [NVWC_NUM_LINES-1:0]   irq_in,
  input  wire logic [NVWC_NUM_LINES-1:0]   irq_enable_in,
  input  wire logic                        hard_fault_in,
  input  wire logic                        svc_in,
  input  wire logic                        pendable_service_in,
  input  wire logic                        tick_in,
  // Non-maskable sources
  input  wire logic [1:0]                  nmi_sel_in,
  input  wire logic                        nmi_pin_in,
  input  wire logic                        clock_lost_in,
  input  wire logic                        brownout_in,
  // Priority writes
  input  wire logic                        prio_wr_in,
  input  wire logic [4:0]                  prio_idx_in,
  input  wire logic [NVWC_PRIO_W-1:0]      prio_data_in,
  // Core handshake
  input  wire logic                        entry_ack_in,
  input  wire logic                        exit_in,
  input  wire logic [1:0]                  power_mode_in,
  input  wire logic                        shutdown_pin_in,
  // Results
  output logic                             req_out,
  output logic [NVWC_EXC_W-1:0]            req_exc_out,
  output logic [NVWC_EXC_W-1:0]            active_exc_out,
  output logic                             wake_out,
  output logic                             use_internal_osc_out
);
  localparam int unsigned STK = 8;

  // Pin input synchroniser stages
  logic [2:0] nmi_pin_sync;
  logic [2:0] next_nmi_pin_sync;
  logic [2:0] sdw_sync;
  logic [2:0] next_sdw_sync;
  logic       nmi_pin_lvl;
  logic       next_nmi_pin_lvl;
  logic       sdw_lvl;
  logic       next_sdw_lvl;
  logic       sdw_toggle;

  // Pending and nesting state
  // one pending bit per line
  logic [NVWC_NUM_LINES-1:0] pend;
  logic [NVWC_NUM_LINES-1:0] next_pend;
  logic [2:0]                core_pend;
  logic [2:0]                next_core_pend;
  logic                      nmi_pend;
  logic                      next_nmi_pend;
  logic                      nmi_prev;
  logic                      next_nmi_prev;
  logic [STK-1:0][5:0]       stk_exc;
  logic [STK-1:0][5:0]       next_stk_exc;
  logic [STK-1:0][2:0]       stk_rank;
  logic [STK-1:0][2:0]       next_stk_rank;
  logic [3:0]                depth;
  logic [3:0]                next_depth;
  logic                      clk_sw;
  logic                      next_clk_sw;
  logic                      next_wake;
  logic [5:0]                next_req_exc;
  logic                      next_req;
  logic [2:0]                req_rank;
  logic [2:0]                next_req_rank;

  logic [NVWC_NUM_LINES+NVWC_NUM_SLOTS-1:0][NVWC_PRIO_W-1:0] prio;
  logic       nmi_src;
  logic [2:0] win_rank;
  logic [5:0] win_exc;
  logic [2:0] act_rank;

  nvwc_prio_mem u_prio (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .wr_en_in   (prio_wr_in),
    .wr_idx_in  (prio_idx_in),
    .wr_data_in (prio_data_in),
    .rd_out     (prio)
  );

  // Programmable level mapped above the fixed ranks
  function automatic logic [2:0] prog_rank(input logic [1:0] p);
    return NVWC_RANK_PROG + {1'b0, p};
  endfunction

  // Pin synchronisers; a level moves once stages two and three agree
  always_comb begin
    next_nmi_pin_sync = {nmi_pin_sync[1:0], nmi_pin_in};
    next_sdw_sync     = {sdw_sync[1:0], shutdown_pin_in};
    next_nmi_pin_lvl  = nmi_pin_lvl;
    next_sdw_lvl      = sdw_lvl;
    if (nmi_pin_sync[2] == nmi_pin_sync[1]) begin
      next_nmi_pin_lvl = nmi_pin_sync[2];
    end
    if (sdw_sync[2] == sdw_sync[1]) begin
      next_sdw_lvl = sdw_sync[2];
    end
  end
  assign sdw_toggle = next_sdw_lvl != sdw_lvl;

  always_comb begin
    unique case (nvwc_nmi_sel_t'(nmi_sel_in))
      NVWC_NMI_OFF:   nmi_src = 1'b0;
      NVWC_NMI_PIN:   nmi_src = nmi_pin_lvl;
      NVWC_NMI_CLK:   nmi_src = clock_lost_in;
      NVWC_NMI_BROWN: nmi_src = brownout_in;
    endcase
  end

  assign act_rank = (depth == '0) ? NVWC_RANK_IDLE : stk_rank[depth - 4'h1];

  // arbitration in polling order, fixed ranks first
  always_comb begin
    win_rank = NVWC_RANK_IDLE;
    win_exc  = NVWC_EXC_NONE;
    // Highest index scanned first so lower numbers win ties
    for (int i = NVWC_NUM_LINES - 1; i >= 0; i--) begin
      if (pend[i] && irq_enable_in[i] && i != NVWC_RSVD_LINE
          && prog_rank(prio[i]) <= win_rank) begin
        win_rank = prog_rank(prio[i]);
        win_exc  = NVWC_EXC_IRQ0 + 6'(i);
      end
    end
    if (core_pend[NVWC_SLOT_TICK]
        && prog_rank(prio[NVWC_NUM_LINES + NVWC_SLOT_TICK]) <= win_rank) begin
      win_rank = prog_rank(prio[NVWC_NUM_LINES + NVWC_SLOT_TICK]);
      win_exc  = NVWC_EXC_TICK;
    end
    if (core_pend[NVWC_SLOT_PSV]
        && prog_rank(prio[NVWC_NUM_LINES + NVWC_SLOT_PSV]) <= win_rank) begin
      win_rank = prog_rank(prio[NVWC_NUM_LINES + NVWC_SLOT_PSV]);
      win_exc  = NVWC_EXC_PENDSRV;
    end
    if (core_pend[NVWC_SLOT_SVC]
        && prog_rank(prio[NVWC_NUM_LINES + NVWC_SLOT_SVC]) <= win_rank) begin
      win_rank = prog_rank(prio[NVWC_NUM_LINES + NVWC_SLOT_SVC]);
      win_exc  = NVWC_EXC_SVCALL;
    end
    if (hard_fault_in) begin
      win_rank = NVWC_RANK_HARD;
      win_exc  = NVWC_EXC_HARD;
    end
    if (nmi_pend) begin
      win_rank = NVWC_RANK_NMI;
      win_exc  = NVWC_EXC_NMI;
    end
  end

  // Pending, nesting and request state
  always_comb begin
    next_pend      = pend;
    next_core_pend = core_pend;
    next_nmi_pend  = nmi_pend;
    next_nmi_prev  = nmi_src;
    next_stk_exc   = stk_exc;
    next_stk_rank  = stk_rank;
    next_depth     = depth;
    // entry clears pending; same-cycle set still wins
    if (entry_ack_in && req_out) begin
      if (req_exc_out >= NVWC_EXC_IRQ0) begin
        next_pend[5'(req_exc_out - NVWC_EXC_IRQ0)] = 1'b0;
      end
      if (req_exc_out == NVWC_EXC_SVCALL) next_core_pend[NVWC_SLOT_SVC] = 1'b0;
      if (req_exc_out == NVWC_EXC_PENDSRV) next_core_pend[NVWC_SLOT_PSV] = 1'b0;
      if (req_exc_out == NVWC_EXC_TICK) next_core_pend[NVWC_SLOT_TICK] = 1'b0;
      if (req_exc_out == NVWC_EXC_NMI) next_nmi_pend = 1'b0;
      if (depth < 4'(STK)) begin
        next_stk_exc[depth]  = req_exc_out;
        // Rank of the number taken, not of a winner that moved since
        next_stk_rank[depth] = req_rank;
        next_depth           = depth + 4'h1;
      end
    end else if (exit_in && depth != '0) begin
      next_depth = depth - 4'h1;
    end
    next_pend = next_pend | (irq_in & NVWC_RSVD_MASK);
    next_core_pend = next_core_pend | {tick_in, pendable_service_in, svc_in};
    if (nmi_src && !nmi_prev) next_nmi_pend = 1'b1;
    next_req     = (win_exc != NVWC_EXC_NONE) && (win_rank < act_rank);
    next_req_exc = win_exc;
    next_req_rank = win_rank;
  end

  always_comb begin
    unique case (nvwc_pmode_t'(power_mode_in))
      NVWC_PM_RUN:   next_wake = 1'b0;
      NVWC_PM_SLEEP: next_wake = nmi_pend || |(pend & NVWC_SLEEP_WAKE);
      NVWC_PM_HIB:   next_wake = nmi_pend || |(pend & NVWC_HIB_WAKE);
      NVWC_PM_SHUT:  next_wake = sdw_toggle;
    endcase
  end

  // clock loss latches switch to internal oscillator
  assign next_clk_sw = clk_sw | clock_lost_in;

  // Register all state; reset holds the core in reset slot
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      nmi_pin_sync <= '0;
      sdw_sync     <= '0;
      nmi_pin_lvl  <= 1'b0;
      sdw_lvl      <= 1'b0;
      pend         <= '0;
      core_pend    <= '0;
      nmi_pend     <= 1'b0;
      nmi_prev     <= 1'b0;
      stk_exc      <= '0;
      stk_rank     <= '0;
      depth        <= '0;
      clk_sw       <= 1'b0;
      wake_out     <= 1'b1;  // Reset always wakes
      req_out      <= 1'b0;
      req_exc_out  <= NVWC_EXC_RESET;
      req_rank     <= NVWC_RANK_IDLE;
    end else begin
      nmi_pin_sync <= next_nmi_pin_sync;
      sdw_sync     <= next_sdw_sync;
      nmi_pin_lvl  <= next_nmi_pin_lvl;
      sdw_lvl      <= next_sdw_lvl;
      pend         <= next_pend;
      core_pend    <= next_core_pend;
      nmi_pend     <= next_nmi_pend;
      nmi_prev     <= next_nmi_prev;
      stk_exc      <= next_stk_exc;
      stk_rank     <= next_stk_rank;
      depth        <= next_depth;
      clk_sw       <= next_clk_sw;
      wake_out     <= next_wake;
      req_out      <= next_req;
      req_exc_out  <= next_req_exc;
      req_rank     <= next_req_rank;
    end
  end

  assign active_exc_out = (depth == '0) ? NVWC_EXC_NONE : stk_exc[depth - 4'h1];
  assign use_internal_osc_out = clk_sw;
endmodule

/* test/nvwc_ctrl_monitor.sv */
// Port checker for the interrupt and wake controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module nvwc_ctrl_chk
  import nvwc_pkg::*;
(
  // Clock, reset and causes
  input wire logic       sys_clk_in,
  input wire logic       srst_in,
  input wire logic       hard_fault_in,
  input wire logic [1:0] nmi_sel_in,
  input wire logic       clock_lost_in,
  input wire logic       entry_ack_in,
  input wire logic [1:0] power_mode_in,
  // Results
  input wire logic       req_out,
  input wire logic [5:0] req_exc_out,
  input wire logic [5:0] active_exc_out,
  input wire logic       wake_out,
  input wire logic       use_internal_osc_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // Fault level held three edges while idle
  sequence s_hf;
    $rose(hard_fault_in) && nmi_sel_in == NVWC_NMI_OFF
      && active_exc_out == NVWC_EXC_NONE ##1 hard_fault_in [*2];
  endsequence
  property p_hard; s_hf |-> req_out && req_exc_out == NVWC_EXC_HARD;
  endproperty
  a_hard: assert property (p_hard)
    else $error("hard fault not requested");
  property p_rsvd; req_out |-> req_exc_out != 6'h21;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved number requested");
  property p_nums; req_out |-> req_exc_out inside
    {6'h02, 6'h03, 6'h0B, 6'h0E, 6'h0F, [6'h10:6'h27]};
  endproperty
  a_nums: assert property (p_nums)
    else $error("unknown exception number");
  // Active level changing masks the one-cycle overlap after entry
  property p_same; req_out && $stable(active_exc_out)
    && active_exc_out != NVWC_EXC_NONE |-> req_exc_out != active_exc_out;
  endproperty
  a_same: assert property (p_same)
    else $error("active handler requested again");
  property p_enter; req_out && entry_ack_in
    |=> active_exc_out == $past(req_exc_out);
  endproperty
  a_enter: assert property (p_enter)
    else $error("entry did not activate request");
  property p_nmi; nmi_sel_in == NVWC_NMI_CLK && $rose(clock_lost_in)
    && active_exc_out != NVWC_EXC_NMI
    |-> ##[1:3] req_out && req_exc_out == NVWC_EXC_NMI;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("clock loss gave no NMI");
  // Reset forces wake high until the first edge after release
  property p_run; (power_mode_in == NVWC_PM_RUN) [*2] ##0 !$past(srst_in)
    |-> !wake_out;
  endproperty
  a_run: assert property (p_run)
    else $error("wake raised in run mode");
  property p_osc; $rose(clock_lost_in) |=> use_internal_osc_out [*4];
  endproperty
  a_osc: assert property (p_osc)
    else $error("internal oscillator not held");
endmodule
bind nvwc_ctrl nvwc_ctrl_chk u_nvwc_ctrl_chk (
  .sys_clk_in, .srst_in, .hard_fault_in, .nmi_sel_in, .clock_lost_in,
  .entry_ack_in, .power_mode_in, .req_out, .req_exc_out, .active_exc_out,
  .wake_out, .use_internal_osc_out
);

/* test/nvwc_core_model.sv */
// Core stand-in: acks requests, returns after a run time.
// Assumes a registered request level from the controller.
`timescale 1ns/1ns
module nvwc_core_model (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  // Bench controls
  input  wire logic       auto_in,
  input  wire logic [3:0] wait_in,
  input  wire logic [3:0] run_in,
  // Controller side
  input  wire logic       req_in,
  output logic            ack_out = 1'h0,
  output logic            exit_out = 1'h0
);
  logic [3:0] wcnt  = 4'h0;
  logic [3:0] rcnt  = 4'h0;
  logic [3:0] depth = 4'h0;
  logic [1:0] cool  = 2'h0;
  // Cool-down stops a second ack while the old request drains
  always @(posedge sys_clk_in) begin
    ack_out  <= 1'h0;
    exit_out <= 1'h0;
    cool     <= cool != 2'h0 ? cool - 2'h1 : 2'h0;
    wcnt     <= req_in ? wcnt + 4'h1 : 4'h0;
    rcnt     <= depth != 4'h0 ? rcnt + 4'h1 : 4'h0;
    if (srst_in) begin
      depth <= 4'h0;
    end else if (auto_in && req_in && cool == 2'h0 && wcnt >= wait_in) begin
      ack_out <= 1'h1;
      cool    <= 2'h3;
      depth   <= depth + 4'h1;
      rcnt    <= 4'h0;
    end else if (auto_in && depth != 4'h0 && rcnt >= run_in) begin
      exit_out <= 1'h1;
      depth    <= depth - 4'h1;
      rcnt     <= 4'h0;
    end
  end
endmodule

/* test/test_nvwc_ctrl.sv */
// Self-checking bench for the interrupt and wake controller.
// Assumes the core model answers requests; 100 MHz clock.
`timescale 1ns/1ns
module test_nvwc_ctrl
  import nvwc_pkg::*;
;
  logic        clk = 1'h0, rst = 1'h1, hf = 1'h0, npin = 1'h0;
  logic        lost = 1'h0, brown = 1'h0, pwr = 1'h0, spin = 1'h0;
  logic        autoc = 1'h0, ack, ext, req, wake, osc;
  logic [23:0] irq = 24'h00_0000;
  logic [23:0] ien = 24'hFF_FFFF;
  logic [2:0]  core = 3'h0;
  logic [1:0]  nsel = 2'h0, pdat = 2'h0, mode = 2'h0;
  logic [4:0]  pidx = 5'h00;
  logic [3:0]  aw = 4'h2, rl = 4'h2;
  logic [5:0]  rexc, act;
  int          num_errors = 0, n_tests = 0;
  always #5 clk = ~clk;
  nvwc_ctrl u_nvwc_ctrl (.sys_clk_in(clk), .srst_in(rst), .irq_in(irq),
    .irq_enable_in(ien), .hard_fault_in(hf), .svc_in(core[0]),
    .pendable_service_in(core[1]), .tick_in(core[2]), .nmi_sel_in(nsel),
    .nmi_pin_in(npin), .clock_lost_in(lost), .brownout_in(brown),
    .prio_wr_in(pwr), .prio_idx_in(pidx), .prio_data_in(pdat),
    .entry_ack_in(ack), .exit_in(ext), .power_mode_in(mode),
    .shutdown_pin_in(spin), .req_out(req), .req_exc_out(rexc),
    .active_exc_out(act), .wake_out(wake), .use_internal_osc_out(osc));
  nvwc_core_model u_nvwc_core_model (.sys_clk_in(clk), .srst_in(rst),
    .auto_in(autoc), .wait_in(aw), .run_in(rl), .req_in(req),
    .ack_out(ack), .exit_out(ext));
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic reset_dut;
    @(posedge clk);
    rst <= 1'h1;
    irq <= 24'h00_0000;
    mode <= NVWC_PM_RUN;
    autoc <= 1'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
  endtask
  task automatic fire(input logic [23:0] v);
    @(posedge clk);
    irq <= v;
    @(posedge clk);
    irq <= 24'h00_0000;
  endtask
  task automatic setp(input logic [4:0] i, input logic [1:0] d);
    @(posedge clk);
    pwr <= 1'h1;
    pidx <= i;
    pdat <= d;
    @(posedge clk);
    pwr <= 1'h0;
  endtask
  // Bounded wait; a missing request reads as 3F
  task automatic wait_req(input logic [5:0] exp);
    for (int i = 0; i < 60 && req !== 1'h1; i++) @(negedge clk);
    chk(req === 1'h1 ? rexc : 6'h3F, exp);
    @(posedge clk);
  endtask
  task automatic no_req(input int n);
    int hits = 0;
    repeat (n) begin
      @(negedge clk);
      if (req === 1'h1) hits++;
    end
    chk(hits[5:0], 6'h00);
    @(posedge clk);
  endtask
  task automatic t_lines;
    @(posedge clk);
    autoc <= 1'h1;
    for (int n = 0; n < 24; n++) begin
      fire(24'h00_0001 << n);
      if (n == 17) no_req(8);
      else wait_req(6'(16 + n));
      repeat (12) @(posedge clk);
    end
  endtask
  task automatic t_prio;
    reset_dut;
    setp(5'h05, 2'h3);
    setp(5'h08, 2'h1);
    fire(24'h00_0120);
    wait_req(6'h18);
    reset_dut;
    fire(24'h00_0018);
    wait_req(6'h13);
    // Masking the tie winner hands the request to the next line
    ien <= 24'hFF_FFF7;
    repeat (3) @(negedge clk);
    chk(rexc, 6'h14);
    @(posedge clk);
    ien <= 24'hFF_FFFF;
    reset_dut;
    @(posedge clk);
    core <= 3'h7;
    @(posedge clk);
    core <= 3'h0;
    wait_req(NVWC_EXC_SVCALL);
    hf <= 1'h1;
    repeat (4) @(negedge clk);
    chk(rexc, NVWC_EXC_HARD);
    @(posedge clk);
    nsel <= NVWC_NMI_PIN;
    npin <= 1'h1;
    repeat (10) @(negedge clk);
    chk(rexc, NVWC_EXC_NMI);
    @(posedge clk);
    hf <= 1'h0;
    npin <= 1'h0;
  endtask
  task automatic t_preempt;
    reset_dut;
    setp(5'h00, 2'h1);
    setp(5'h01, 2'h1);
    aw <= 4'h0;
    rl <= 4'hF;
    autoc <= 1'h1;
    fire(24'h00_0001);
    wait_req(6'h10);
    // Short gap so line 1 arrives well inside the first handler
    repeat (2) @(posedge clk);
    fire(24'h00_0002);
    no_req(6);
    fire(24'h00_0004);
    wait_req(6'h12);
    repeat (6) @(posedge clk);
    chk(act, 6'h12);
    wait_req(6'h11);
  endtask
  task automatic t_nmi;
    for (int s = 1; s < 4; s++) begin
      reset_dut;
      nsel <= 2'(s);
      @(posedge clk);
      npin <= s == 1;
      lost <= s == 2;
      brown <= s == 3;
      wait_req(NVWC_EXC_NMI);
      chk({5'h00, osc}, {5'h00, lost});
      npin <= 1'h0;
      lost <= 1'h0;
      brown <= 1'h0;
    end
  endtask
  // Sleep and hibernate cases, then the shutdown pin
  task automatic t_wake;
    logic [1:0] md [6] = '{NVWC_PM_SLEEP, NVWC_PM_SLEEP, NVWC_PM_SLEEP,
                           NVWC_PM_HIB, NVWC_PM_HIB, NVWC_PM_HIB};
    int         ln [6] = '{7, 8, 10, 4, 3, 1};
    logic [5:0] ex = 6'h34;
    for (int i = 0; i < 6; i++) begin
      reset_dut;
      mode <= md[i];
      fire(24'h00_0001 << ln[i]);
      repeat (5) @(negedge clk);
      chk({5'h00, wake}, {5'h00, ex[i]});
    end
    reset_dut;
    mode <= NVWC_PM_SHUT;
    fire(24'h00_0001);
    repeat (6) @(negedge clk);
    chk({5'h00, wake}, 6'h00);
    @(posedge clk);
    spin <= 1'h1;
    // Pin wake is a one-cycle pulse; catch it while it stands
    for (int i = 0; i < 40 && wake !== 1'h1; i++) @(negedge clk);
    chk({5'h00, wake}, 6'h01);
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    reset_dut;
    @(negedge clk);
    chk(rexc, NVWC_EXC_RESET);
    t_lines;
    t_prio;
    t_preempt;
    t_nmi;
    t_wake;
    report_and_stop;
  end
  // Hang guard, well past the expected run
  initial begin
    #200000;
    num_errors++;
    report_and_stop;
  end
endmodule
